/* File: rtl/pcko_clock_out.sv */
// Purpose: Programmable clock output with direct and interrupt enable
// Assumes: Oscillator, taps, timer and event inputs are asynchronous levels
// Notes:   The oscillator is oversampled at 50 MHz; pin edges carry
//          up to three mclk periods of delay and one period of jitter.
//
// Notes on behaviour
// - Select field picks one of eight sources
// - Raw oscillator passes through uncorrected
// - Divided taps come from corrected prescaler
// - Flag, enable, select applied on oscillator fall
// - Backup power state forces pin low
// - Reset: sync on, enable on, select raw
// - Low when enable bit and flag both clear or select 111
// - Reset bit or seconds write disturbs divided taps
// - Enable bit gates selected signal directly when sync off
// - Enabled interrupt event with enable bit clear sets flag, starts output
// - Clearing interrupt enable never stops running output
// - Writing zero to flag clears it, stops output
// - Synced start at first selected source fall
// - Synced stop after clear, bus stop, fall
// - Timer source ignores the sync bit
// - Correction pulses may reshape divided outputs
// - Reset bit restarts prescaler, keeps seconds

`timescale 1ns/1ns

module pcko_clock_out
    import pcko_pkg::*;
(
    input wire logic mclk,
    input wire logic srst,
    // Asynchronous inputs from the oscillator domain
    input wire logic osc_clk_in,
    input wire logic [TAP_W-1:0] prescaler_taps,
    input wire logic timer_irq_signal,
    input wire logic irq_event,
    input wire logic backup_power_state,
    // Control writes from the bus logic, same clock
    input wire logic cfg_wr,
    input wire logic cfg_out_enable,
    input wire logic [2:0] cfg_freq_select,
    input wire logic cfg_sync_enable,
    input wire logic cfg_irq_clock_enable,
    input wire logic flag_clr_wr,
    input wire logic reset_bit_wr,
    input wire logic seconds_wr,
    input wire logic bus_stop,
    // Outputs
    output logic clock_out_pin,
    output logic irq_clock_flag,
    output logic out_enable,
    output logic [2:0] freq_select,
    output logic sync_enable,
    output logic irq_clock_enable,
    output logic prescaler_restart
);

    // ============================================================
    // Declarations
    logic [ASYNC_W-1:0] async_bus;
    logic [ASYNC_W-1:0] sync_bus;
    logic osc_s;
    logic [TAP_W-1:0] taps_s;
    logic timer_s;
    logic event_s;
    logic backup_s;

    logic osc_prev_r;
    logic event_prev_r;
    logic sel_prev_r;
    logic osc_fall;
    logic event_rise;
    logic sel_fall;

    logic eff_oe_r;
    logic eff_flag_r;
    logic [2:0] eff_fs_r;
    logic stop_seen_r;

    logic sel_lvl;
    logic sel_is_low;
    logic sel_is_timer;
    logic en_req;
    logic bypass;
    logic gate_open;
    logic flag_set;
    logic pin_nxt;

    pcko_gate_t gate_r;
    pcko_gate_t gate_nxt;

    // ============================================================
    // Input synchronisers
    // All slow-domain signals are levels, so a plain double flop
    // per bit is enough; one vector keeps them in a single instance.
    assign async_bus = {backup_power_state, irq_event, timer_irq_signal,
                        prescaler_taps, osc_clk_in};

    pcko_sync #(
        .WIDTH(ASYNC_W)
    ) u_sync (
        .mclk(mclk),
        .srst(srst),
        .async_in(async_bus),
        .sync_out(sync_bus)
    );

    // Unpack synchronised bundle
    assign osc_s = sync_bus[ABUS_OSC];
    assign taps_s = sync_bus[ABUS_TAP_HI:ABUS_TAP_LO];
    assign timer_s = sync_bus[ABUS_TIMER];
    assign event_s = sync_bus[ABUS_EVENT];
    assign backup_s = sync_bus[ABUS_BACKUP];

    // ============================================================
    // Source selection on the applied select value
    pcko_src_sel u_src_sel (
        .freq_select(eff_fs_r),
        .osc_lvl(osc_s),
        .tap_lvl(taps_s),
        .timer_lvl(timer_s),
        .sel_lvl(sel_lvl),
        .sel_is_low(sel_is_low),
        .sel_is_timer(sel_is_timer)
    );

    // ============================================================
    // Edge detection on synchronised levels
    always_ff @(posedge mclk) begin
        if (srst) begin
            osc_prev_r <= 1'b0;
            event_prev_r <= 1'b0;
            sel_prev_r <= 1'b0;
        end else begin
            osc_prev_r <= osc_s;
            event_prev_r <= event_s;
            sel_prev_r <= sel_lvl;
        end
    end

    // Falls of the oscillator and the selected source, event rise
    assign osc_fall = osc_prev_r & ~osc_s;
    assign sel_fall = sel_prev_r & ~sel_lvl;
    assign event_rise = event_s & ~event_prev_r;

    // ============================================================
    // Software-visible control bits
    // These are what software reads back; the gate uses the applied
    // copies below for enable, flag and select; sync_enable is read directly.
    always_ff @(posedge mclk) begin
        if (srst) begin
            out_enable <= RST_OUT_ENABLE;
            freq_select <= RST_FREQ_SELECT;
            sync_enable <= RST_SYNC_ENABLE;
            irq_clock_enable <= RST_IRQ_CLOCK_ENABLE;
        end else if (cfg_wr) begin
            out_enable <= cfg_out_enable;
            freq_select <= cfg_freq_select;
            sync_enable <= cfg_sync_enable;
            irq_clock_enable <= cfg_irq_clock_enable;
        end
    end

    // ============================================================
    // Interrupt clock flag
    // Only an event while the enable bit is clear arms the flag.
    // Dropping the interrupt enable later leaves a set flag alone.
    assign flag_set = event_rise & irq_clock_enable & ~out_enable;

    // Set beats a simultaneous clear so no event is lost
    always_ff @(posedge mclk) begin
        if (srst) begin
            irq_clock_flag <= RST_IRQ_CLOCK_FLAG;
        end else if (flag_set) begin
            irq_clock_flag <= 1'b1;
        end else if (flag_clr_wr) begin
            irq_clock_flag <= 1'b0;
        end
    end

    // ============================================================
    // Applied copies, updated only on oscillator falling edges
    always_ff @(posedge mclk) begin
        if (srst) begin
            eff_oe_r <= RST_OUT_ENABLE;
            eff_flag_r <= RST_IRQ_CLOCK_FLAG;
            eff_fs_r <= RST_FREQ_SELECT;
        end else if (osc_fall) begin
            eff_oe_r <= out_enable;
            eff_flag_r <= irq_clock_flag;
            eff_fs_r <= freq_select;
        end
    end

    // ============================================================
    // Bus stop tracking for the synchronised disable
    // A stop counts only if it follows the last control write,
    // so stale stops from earlier transfers cannot end the output.
    always_ff @(posedge mclk) begin
        if (srst) begin
            stop_seen_r <= 1'b0;
        end else if (bus_stop) begin
            stop_seen_r <= 1'b1;
        end else if (cfg_wr | flag_clr_wr) begin
            stop_seen_r <= 1'b0;
        end
    end

    // ============================================================
    // Gate request and bypass
    assign en_req = eff_oe_r | eff_flag_r;
    assign bypass = ~sync_enable | sel_is_timer;

    // ============================================================
    // Gate state machine
    // Synchronised mode waits for a selected source fall on both
    // start and stop so the pin never shows a runt pulse.
    always_comb begin
        gate_nxt = gate_r;
        case (gate_r)
            GATE_OFF: begin
                if (en_req) begin
                    gate_nxt = bypass ? GATE_ON : GATE_ARM;
                end
            end
            GATE_ARM: begin
                if (!en_req) begin
                    gate_nxt = GATE_OFF;
                end else if (bypass || sel_fall) begin
                    gate_nxt = GATE_ON;
                end
            end
            GATE_ON: begin
                if (!en_req) begin
                    gate_nxt = bypass ? GATE_OFF : GATE_WAIT_STOP;
                end
            end
            GATE_WAIT_STOP: begin
                if (en_req) begin
                    gate_nxt = GATE_ON;
                end else if (bypass) begin
                    gate_nxt = GATE_OFF;
                end else if (stop_seen_r) begin
                    gate_nxt = GATE_DRAIN;
                end
            end
            GATE_DRAIN: begin
                if (en_req) begin
                    gate_nxt = GATE_ON;
                end else if (bypass || sel_fall) begin
                    gate_nxt = GATE_OFF;
                end
            end
            default: begin
                gate_nxt = GATE_OFF;
            end
        endcase
    end

    // Gate state register; reset starts with output running
    always_ff @(posedge mclk) begin
        if (srst) begin
            gate_r <= GATE_ON;
        end else begin
            gate_r <= gate_nxt;
        end
    end

    // ============================================================
    // Pin level
    // The gate stays open until the disabling fall, so the last
    // high phase of the source completes before the pin goes low.
    assign gate_open = (gate_r == GATE_ON) || (gate_r == GATE_WAIT_STOP) ||
                       (gate_r == GATE_DRAIN);

    // Backup state and select 111 override everything
    assign pin_nxt = gate_open & sel_lvl & ~sel_is_low & ~backup_s;

    // Registered pin driver
    always_ff @(posedge mclk) begin
        if (srst) begin
            clock_out_pin <= 1'b0;
        end else begin
            clock_out_pin <= pin_nxt;
        end
    end

    // ============================================================
    // Prescaler restart request
    // The divider itself lives outside; this one-cycle pulse makes
    // it restart its divided stages, which changes the current
    // period of every divided or timer selection on the pin, cutting it short or stretching it.
    always_ff @(posedge mclk) begin
        if (srst) begin
            prescaler_restart <= 1'b0;
        end else begin
            prescaler_restart <= reset_bit_wr | seconds_wr;
        end
    end

endmodule // pcko_clock_out

/* File: inc/pcko_pkg.sv */
// Purpose: Shared constants for the programmable clock output block
// Assumes: One 50 MHz system clock; oscillator and taps arrive asynchronously
// Notes:   Select codes, tap indices and reset values live here only

package pcko_pkg;

    // ============================================================
    // Clocking
    localparam int unsigned MCLK_HZ = 50000000;
    localparam int unsigned OSC_HZ = 32768;

    // ============================================================
    // Source select codes
    localparam logic [2:0] FS_RAW = 3'h0;
    localparam logic [2:0] FS_8192 = 3'h1;
    localparam logic [2:0] FS_1024 = 3'h2;
    localparam logic [2:0] FS_64 = 3'h3;
    localparam logic [2:0] FS_32 = 3'h4;
    localparam logic [2:0] FS_1HZ = 3'h5;
    localparam logic [2:0] FS_TIMER = 3'h6;
    localparam logic [2:0] FS_LOW = 3'h7;

    // ============================================================
    // Prescaler tap vector layout
    localparam int TAP_W = 5;
    localparam int TAP_8192 = 0;
    localparam int TAP_1024 = 1;
    localparam int TAP_64 = 2;
    localparam int TAP_32 = 3;
    localparam int TAP_1HZ = 4;

    // Width of the asynchronous input bundle: osc, taps, timer, event, backup
    localparam int ASYNC_W = TAP_W + 4;

    // Bit positions inside the synchronised input bundle
    localparam int ABUS_OSC = 0;
    localparam int ABUS_TAP_LO = 1;
    localparam int ABUS_TAP_HI = TAP_W;
    localparam int ABUS_TIMER = TAP_W + 1;
    localparam int ABUS_EVENT = TAP_W + 2;
    localparam int ABUS_BACKUP = TAP_W + 3;

    // ============================================================
    // Reset values
    localparam logic RST_SYNC_ENABLE = 1'b1;
    localparam logic RST_OUT_ENABLE = 1'b1;
    localparam logic RST_IRQ_CLOCK_ENABLE = 1'b0;
    localparam logic RST_IRQ_CLOCK_FLAG = 1'b0;
    localparam logic [2:0] RST_FREQ_SELECT = FS_RAW;

    // ============================================================
    // Output gate states
    typedef enum logic [2:0] {
        GATE_OFF,
        GATE_ARM,
        GATE_ON,
        GATE_WAIT_STOP,
        GATE_DRAIN
    } pcko_gate_t;

endpackage

/* File: rtl/pcko_sync.sv */
// Purpose: Two-stage synchroniser for a vector of asynchronous levels
// Assumes: Each bit is an independent level; no word coherence is needed
// Notes:   Only the second stage leaves this module

`timescale 1ns/1ns

module pcko_sync #(
    parameter int WIDTH = 1
) (
    input wire logic mclk,
    input wire logic srst,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_r;

    // ============================================================
    // Double flop; first stage feeds only the second
    always_ff @(posedge mclk) begin
        if (srst) begin
            meta_r <= '0;
            sync_out <= '0;
        end else begin
            meta_r <= async_in;
            sync_out <= meta_r;
        end
    end

endmodule // pcko_sync

/* File: rtl/pcko_src_sel.sv */
// Purpose: Picks the clock output source level from the select field
// Assumes: All inputs already synchronised to mclk
// Notes:   Pure decode, no state

`timescale 1ns/1ns

module pcko_src_sel
    import pcko_pkg::*;
(
    input wire logic [2:0] freq_select,
    input wire logic osc_lvl,
    input wire logic [TAP_W-1:0] tap_lvl,
    input wire logic timer_lvl,
    output logic sel_lvl,
    output logic sel_is_low,
    output logic sel_is_timer
);

    // ============================================================
    // Source mux; raw oscillator bypasses offset correction
    assign sel_lvl = (freq_select == FS_RAW) ? osc_lvl :
                     (freq_select == FS_8192) ? tap_lvl[TAP_8192] :
                     (freq_select == FS_1024) ? tap_lvl[TAP_1024] :
                     (freq_select == FS_64) ? tap_lvl[TAP_64] :
                     (freq_select == FS_32) ? tap_lvl[TAP_32] :
                     (freq_select == FS_1HZ) ? tap_lvl[TAP_1HZ] :
                     (freq_select == FS_TIMER) ? timer_lvl : 1'b0;

    // Flags used by the gate control
    assign sel_is_low = (freq_select == FS_LOW);
    assign sel_is_timer = (freq_select == FS_TIMER);

endmodule // pcko_src_sel

/* File: testbench/pcko_clock_out_chk.sv */
// Purpose: Port-level assertions for the clock output block
// Assumes: One mclk domain, srst synchronous active high
// Notes:   Bound onto every pcko_clock_out instance

`timescale 1ns/1ns

module pcko_clock_out_chk
    import pcko_pkg::*;
(
    input wire logic mclk,
    input wire logic srst,
    input wire logic irq_event,
    input wire logic backup_power_state,
    input wire logic cfg_wr,
    input wire logic cfg_out_enable,
    input wire logic [2:0] cfg_freq_select,
    input wire logic cfg_sync_enable,
    input wire logic cfg_irq_clock_enable,
    input wire logic flag_clr_wr,
    input wire logic reset_bit_wr,
    input wire logic seconds_wr,
    input wire logic clock_out_pin,
    input wire logic irq_clock_flag,
    input wire logic out_enable,
    input wire logic [2:0] freq_select,
    input wire logic sync_enable,
    input wire logic irq_clock_enable,
    input wire logic prescaler_restart
);
    // ============================================================
    // Properties, all on mclk
    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst);

    chk_reset_defaults: assert property (
        $fell(srst) |-> out_enable && sync_enable && freq_select == FS_RAW
            && !irq_clock_enable && !irq_clock_flag)
        else $error("control defaults wrong after reset");
    chk_cfg_readback: assert property (
        cfg_wr |=> freq_select == $past(cfg_freq_select) && out_enable == $past(cfg_out_enable)
            && sync_enable == $past(cfg_sync_enable)
            && irq_clock_enable == $past(cfg_irq_clock_enable))
        else $error("control readback does not follow write");
    // Five cycles covers the two-stage synchroniser plus the pin register
    chk_backup_low: assert property (
        backup_power_state [*5] |-> !clock_out_pin)
        else $error("pin active in backup state");
    chk_flag_sticky: assert property (
        irq_clock_flag && !flag_clr_wr |=> irq_clock_flag)
        else $error("flag dropped without clear");
    chk_flag_clear: assert property (
        (!irq_event) [*4] ##0 flag_clr_wr |=> !irq_clock_flag)
        else $error("flag survived clear");
    chk_flag_cause: assert property (
        $rose(irq_clock_flag) |-> $past(irq_clock_enable) && !$past(out_enable))
        else $error("flag set while not armed");
    chk_flag_set: assert property (
        $rose(irq_event) && irq_clock_enable && !out_enable && !cfg_wr |-> ##[1:6] irq_clock_flag)
        else $error("armed event did not set flag");
    chk_restart_pulse: assert property (
        !$past(srst) |-> prescaler_restart == $past(reset_bit_wr || seconds_wr))
        else $error("prescaler restart pulse wrong");
endmodule // pcko_clock_out_chk

bind pcko_clock_out pcko_clock_out_chk u_chk (.mclk, .srst, .irq_event, .backup_power_state,
    .cfg_wr, .cfg_out_enable, .cfg_freq_select, .cfg_sync_enable, .cfg_irq_clock_enable,
    .flag_clr_wr, .reset_bit_wr, .seconds_wr, .clock_out_pin, .irq_clock_flag, .out_enable,
    .freq_select, .sync_enable, .irq_clock_enable, .prescaler_restart);

/* File: testbench/pcko_osc_model.sv */
// Purpose: Oscillator, prescaler and timer source for the clock output
// Assumes: Oscillator runs free, unrelated in phase to mclk
// Notes:   Divisions shortened so every tap shows within a short run

`timescale 1ns/1ns

module pcko_osc_model
    import pcko_pkg::*;
(
    input wire logic restart,
    output logic osc_clk_in,
    output logic [TAP_W-1:0] prescaler_taps,
    output logic timer_irq_signal
);
    logic [6:0] div_r = 7'h00;

    // ============================================================
    // Oscillator: 400 ns period, odd start offset against mclk
    initial begin
        osc_clk_in = 1'b0;
        #7;
        forever #200 osc_clk_in = ~osc_clk_in;
    end

    // Prescaler counts oscillator falls; a restart clears all stages
    always @(negedge osc_clk_in or posedge restart) begin
        if (restart) begin
            div_r <= 7'h00;
        end else begin
            div_r <= div_r + 7'h01;
        end
    end
    assign prescaler_taps = div_r[5:1];
    assign timer_irq_signal = div_r[6];
endmodule // pcko_osc_model

/* File: testbench/tb.sv */
// Purpose: Self-checking bench for the clock output block
// Assumes: Partner model supplies oscillator, taps and timer
// Notes:   Pin activity is judged by counting rises in fixed windows

`timescale 1ns/1ns

module tb
    import pcko_pkg::*;
;
    localparam int OSC_CYC = 20; // Model oscillator period in mclk cycles
    logic mclk = 1'b0;
    logic srst = 1'b1;
    logic irq_event = 1'b0;
    logic backup_power_state = 1'b0;
    logic cfg_wr = 1'b0;
    logic cfg_out_enable = 1'b1;
    logic [2:0] cfg_freq_select = 3'h0;
    logic cfg_sync_enable = 1'b1;
    logic cfg_irq_clock_enable = 1'b0;
    logic flag_clr_wr = 1'b0;
    logic reset_bit_wr = 1'b0;
    logic seconds_wr = 1'b0;
    logic bus_stop = 1'b0;
    logic osc_clk_in, timer_irq_signal, clock_out_pin, irq_clock_flag;
    logic out_enable, sync_enable, irq_clock_enable, prescaler_restart;
    logic [TAP_W-1:0] prescaler_taps;
    logic [2:0] freq_select;
    int n_errors = 0;
    int checks_done = 0;
    int got;

    initial begin
        forever #10 mclk = ~mclk;
    end

    pcko_clock_out dut (.mclk, .srst, .osc_clk_in, .prescaler_taps, .timer_irq_signal,
        .irq_event, .backup_power_state, .cfg_wr, .cfg_out_enable, .cfg_freq_select,
        .cfg_sync_enable, .cfg_irq_clock_enable, .flag_clr_wr, .reset_bit_wr, .seconds_wr,
        .bus_stop, .clock_out_pin, .irq_clock_flag, .out_enable, .freq_select, .sync_enable,
        .irq_clock_enable, .prescaler_restart);
    pcko_osc_model u_osc (.restart(prescaler_restart), .osc_clk_in, .prescaler_taps,
        .timer_irq_signal);

    // ============================================================
    // Helpers
    task automatic end_sim();
        if (n_errors == 0 && checks_done > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // Source period in mclk cycles as the model builds it; 0 for constant low
    function automatic int src_period(input logic [2:0] sel);
        if (sel == FS_LOW) return 0;
        return OSC_CYC * (sel == FS_RAW ? 1 : 2 << sel);
    endfunction

    // Call at a falling edge, where the design's outputs have settled
    task automatic check_bit(input logic got_b, input logic exp_b, input string what);
        checks_done++;
        if (got_b !== exp_b) begin
            n_errors++;
            $display("mismatch at %0t: %s", $time, what);
        end
    endtask

    // One rise of slack: window edges cut periods at arbitrary phase
    task automatic check_cnt(input int got_n, input int exp_n, input string what);
        checks_done++;
        if (exp_n == 0 ? got_n != 0 : (got_n < exp_n - 1 || got_n > exp_n + 1)) begin
            n_errors++;
            $display("mismatch at %0t: %s got %0d rises, want %0d", $time, what, got_n, exp_n);
        end
    endtask

    task automatic count_rises(input int win, output int n);
        logic prev;
        n = 0;
        @(negedge mclk);
        prev = clock_out_pin;
        repeat (win) begin
            @(negedge mclk);
            if (clock_out_pin === 1'b1 && prev !== 1'b1) n++;
            prev = clock_out_pin;
        end
        @(posedge mclk);
    endtask

    task automatic write_cfg(input logic oe, input logic [2:0] sel, input logic sy,
                             input logic ie);
        @(posedge mclk);
        cfg_wr <= 1'b1;
        cfg_out_enable <= oe;
        cfg_freq_select <= sel;
        cfg_sync_enable <= sy;
        cfg_irq_clock_enable <= ie;
        @(posedge mclk);
        cfg_wr <= 1'b0;
    endtask

    // 0 bus stop, 1 flag clear, 2 reset bit, 3 seconds write
    task automatic pulse(input int which);
        @(posedge mclk);
        case (which)
            0: bus_stop <= 1'b1;
            1: flag_clr_wr <= 1'b1;
            2: reset_bit_wr <= 1'b1;
            default: seconds_wr <= 1'b1;
        endcase
        @(posedge mclk);
        {bus_stop, flag_clr_wr, reset_bit_wr, seconds_wr} <= 4'h0;
    endtask

    // ============================================================
    // Main sequence
    initial begin
        logic sy;
        int p;
        void'($urandom(32'h974b));
        repeat (5) @(posedge mclk);
        srst <= 1'b0;
        count_rises(400, got);
        check_cnt(got, 400 / OSC_CYC, "default raw output");
        // Every select code; enables cleared before each change of source
        for (int s = 0; s < 8; s++) begin
            sy = 1'($urandom_range(1, 0));
            p = src_period(3'(s));
            write_cfg(1'b0, freq_select, sy, 1'b0);
            pulse(0);
            // Let the old source finish its synchronised stop first
            repeat (src_period(freq_select) + 40) @(posedge mclk);
            write_cfg(1'b1, 3'(s), sy, 1'b0);
            repeat (2 * p + 40) @(posedge mclk);
            count_rises(5120, got);
            check_cnt(got, p == 0 ? 0 : 5120 / p, "source sweep");
        end
        // Backup state holds the pin low, then the source returns
        write_cfg(1'b1, FS_RAW, 1'b1, 1'b0);
        backup_power_state <= 1'b1;
        repeat (8) @(posedge mclk);
        count_rises(400, got);
        check_cnt(got, 0, "backup low");
        backup_power_state <= 1'b0;
        repeat (8) @(posedge mclk);
        count_rises(400, got);
        check_cnt(got, 20, "backup resume");
        // Synchronised stop needs a bus stop after the clear
        write_cfg(1'b0, FS_RAW, 1'b1, 1'b0);
        count_rises(400, got);
        check_cnt(got, 20, "stop before bus stop");
        pulse(0);
        repeat (40) @(posedge mclk);
        count_rises(400, got);
        check_cnt(got, 0, "stopped after bus stop");
        // Unsynchronised enable bit gates the source directly
        write_cfg(1'b1, FS_RAW, 1'b0, 1'b0);
        repeat (40) @(posedge mclk);
        count_rises(400, got);
        check_cnt(got, 20, "direct enable");
        write_cfg(1'b0, FS_RAW, 1'b0, 1'b0);
        repeat (40) @(posedge mclk);
        count_rises(400, got);
        check_cnt(got, 0, "direct disable");
        // Event with interrupt enable clear leaves the flag alone
        irq_event <= 1'b1;
        repeat (10) @(posedge mclk);
        irq_event <= 1'b0;
        @(negedge mclk);
        check_bit(irq_clock_flag, 1'b0, "flag without enable");
        write_cfg(1'b0, FS_RAW, 1'b1, 1'b1);
        repeat (4) @(posedge mclk);
        irq_event <= 1'b1;
        repeat (10) @(posedge mclk);
        irq_event <= 1'b0;
        @(negedge mclk);
        check_bit(irq_clock_flag, 1'b1, "flag after event");
        repeat (40) @(posedge mclk);
        count_rises(400, got);
        check_cnt(got, 20, "event output");
        write_cfg(1'b0, FS_RAW, 1'b1, 1'b0);
        pulse(0);
        repeat (40) @(posedge mclk);
        count_rises(400, got);
        check_cnt(got, 20, "output after enable cleared");
        @(negedge mclk);
        check_bit(irq_clock_flag, 1'b1, "flag held");
        pulse(1);
        pulse(0);
        repeat (40) @(posedge mclk);
        count_rises(400, got);
        check_cnt(got, 0, "flag clear stops");
        @(negedge mclk);
        check_bit(irq_clock_flag, 1'b0, "flag cleared");
        // Reset bit and seconds write restart the prescaler
        pulse(2);
        @(negedge mclk);
        check_bit(prescaler_restart, 1'b1, "restart after reset bit");
        pulse(3);
        @(negedge mclk);
        check_bit(prescaler_restart, 1'b1, "restart after seconds write");
        @(negedge mclk);
        check_bit(prescaler_restart, 1'b0, "restart pulse too long");
        repeat (4) @(posedge mclk);
        end_sim();
    end
endmodule // tb
